// ### serial_latch_bus_master.sv
// Operation
// - Primary bus: clock, shared data, four latches.
// - Send 24 gapless bits, then latch.
// - Release data line after each transfer.
// - Launch and sample on bus clock falls.
// - Latch 0 and 1 pulse 500 ns.
// - Latch 3 programmable primary, 500 ns aux.
// - Aux clock 126 kHz only during transfers.
// - Aux data zero outside transfers.
// - Three bytes form one word, MSB first.
// - Power-down bit 7 stops interface, not clock.
// - Width field steps 100 bus periods.
// - Width counts down; writing 0 ends pulse.
// - Programmed width ignored for aux transfers.
// - Control bit 7 starts; fields pick mode.
// - Start enables shifting, one bit per fall.
// - Latch follows on fall after bit 24.
// - Send-done pulses with the latch.
// - Control word clears when transfer completes.
// - Three readable answer bytes captured.
// - Answer sampled from fifth fall, 24 bits.
`timescale 1ns/10ps
`include "serial_latch_map.svh"
`default_nettype none

module serial_latch_bus_master #(
    parameter int LATCH_CYC = `LATCH_PULSE_CYC,
    parameter int AUX_HALF = `AUX_HALF_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Primary bus
    input wire logic BUS_CLOCK_IN,
    output logic BUS_CLOCK_OUT,
    input wire logic SERIAL_I,
    output logic SERIAL_O,
    output logic SERIAL_OE,
    output logic [3:0] LATCH,
    // Auxiliary bus
    output logic AUX_BUS_CLOCK,
    output logic AUX_BUS_DATA,
    // Events
    output logic SEND_DONE,
    output logic RECEIVE_DONE_IRQ
);

    // ****************************************
    // Reset and input synchronisers
    // ****************************************
    logic rst_s1, rst_n;
    logic bclk_s1, bclk_s2, bclk_q;
    logic sdi_s1, sdi_s2;
    logic bfall, en, bfall_en;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bclk_s1 <= 1'b0;
            bclk_s2 <= 1'b0;
            bclk_q <= 1'b0;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
            BUS_CLOCK_OUT <= 1'b0;
        end else begin
            bclk_s1 <= BUS_CLOCK_IN;
            bclk_s2 <= bclk_s1;
            bclk_q <= bclk_s2;
            sdi_s1 <= SERIAL_I;
            sdi_s2 <= sdi_s1;
            BUS_CLOCK_OUT <= bclk_s2;
        end
    end

    assign bfall = bclk_q & ~bclk_s2;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] tx0_r, tx1_r, tx2_r, power_r;
    logic [7:0] rx0_r, rx1_r, rx2_r;
    logic [6:0] width_r;
    serial_latch_pkg::transfer_control_t ctrl_r;
    serial_latch_pkg::xfer_state_t state_r;
    logic fire, fire_primary, recv_load;
    logic l3_run_r, done_dly_r;
    logic [6:0] step_cnt_r;

    assign en = ~power_r[`POWER_DOWN_BIT];
    assign bfall_en = bfall & en;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off);
        wr_hit = (a == off);
    endfunction

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx0_r <= 8'h00;
            tx1_r <= 8'h00;
            tx2_r <= 8'h00;
            power_r <= `POWER_RESET;
        end else if (WR) begin
            if (wr_hit(ADDR, `REG_TX_FIRST)) tx0_r <= WDATA;
            if (wr_hit(ADDR, `REG_TX_SECOND)) tx1_r <= WDATA;
            if (wr_hit(ADDR, `REG_TX_THIRD)) tx2_r <= WDATA;
            if (wr_hit(ADDR, `REG_POWER)) power_r <= WDATA;
        end
    end

    // A software write in the completion cycle wins over the clear.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CONTROL_RESET;
        end else if (WR && wr_hit(ADDR, `REG_CONTROL)) begin
            ctrl_r <= WDATA;
        end else if (fire) begin
            ctrl_r <= `CONTROL_RESET;
        end
    end

    // Width counts down in steps of 100 bus periods once the word is sent.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            width_r <= `WIDTH_RESET;
            step_cnt_r <= 7'h00;
        end else if (WR && wr_hit(ADDR, `REG_L3_WIDTH)) begin
            width_r <= WDATA[6:0];
            step_cnt_r <= 7'h00;
        end else if (l3_run_r && bfall_en && width_r != 7'h00) begin
            if (step_cnt_r == 7'(`WIDTH_STEP_PERIODS - 1)) begin
                step_cnt_r <= 7'h00;
                width_r <= width_r - 7'h01;
            end else begin
                step_cnt_r <= step_cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `REG_CONTROL: RDATA <= ctrl_r;
                `REG_L3_WIDTH: RDATA <= {1'b0, width_r};
                `REG_POWER: RDATA <= power_r;
                `REG_RX_FIRST: RDATA <= rx0_r;
                `REG_RX_SECOND: RDATA <= rx1_r;
                `REG_RX_THIRD: RDATA <= rx2_r;
                `REG_STATUS: RDATA <= {4'h0, state_r};
                default: RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    logic [23:0] sh_r, rsh_r, rx_word;
    logic [4:0] cnt_r;
    logic [8:0] half_r;
    logic [5:0] phase_r;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= serial_latch_pkg::ST_IDLE;
            sh_r <= 24'h000000;
            rsh_r <= 24'h000000;
            cnt_r <= 5'h00;
            half_r <= 9'h000;
            phase_r <= 6'h00;
            SERIAL_O <= 1'b0;
            SERIAL_OE <= 1'b0;
            AUX_BUS_CLOCK <= 1'b0;
            AUX_BUS_DATA <= 1'b0;
        end else if (en) begin
            case (state_r)
                serial_latch_pkg::ST_IDLE: begin
                    cnt_r <= 5'h00;
                    half_r <= 9'h000;
                    phase_r <= 6'h00;
                    if (ctrl_r.go && ctrl_r.bus_select_bit) begin
                        sh_r <= {tx0_r, tx1_r, tx2_r};
                        state_r <= serial_latch_pkg::ST_P_SHIFT;
                    end else if (ctrl_r.go) begin
                        AUX_BUS_DATA <= tx0_r[7];
                        sh_r <= {tx0_r[6:0], tx1_r, tx2_r, 1'b0};
                        state_r <= serial_latch_pkg::ST_A_SHIFT;
                    end
                end
                serial_latch_pkg::ST_P_SHIFT: begin
                    if (bfall) begin
                        if (cnt_r != 5'(`WORD_BITS)) begin
                            SERIAL_O <= sh_r[23];
                            SERIAL_OE <= 1'b1;
                            sh_r <= {sh_r[22:0], 1'b0};
                            cnt_r <= cnt_r + 5'h01;
                        end else begin
                            SERIAL_OE <= 1'b0;
                            SERIAL_O <= 1'b0;
                            cnt_r <= 5'h00;
                            state_r <= ctrl_r.answer_request ?
                                serial_latch_pkg::ST_P_RECV : serial_latch_pkg::ST_IDLE;
                        end
                    end
                end
                serial_latch_pkg::ST_P_RECV: begin
                    if (bfall) begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r >= 5'(`ANSWER_FIRST_EDGE - 1)) begin
                            rsh_r <= {rsh_r[22:0], sdi_s2};
                        end
                        if (cnt_r == 5'(`ANSWER_FIRST_EDGE + `WORD_BITS - 2)) begin
                            state_r <= serial_latch_pkg::ST_IDLE;
                        end
                    end
                end
                serial_latch_pkg::ST_A_SHIFT: begin
                    if (half_r == 9'(AUX_HALF - 1)) begin
                        half_r <= 9'h000;
                        phase_r <= phase_r + 6'h01;
                        if (phase_r == 6'(2 * `WORD_BITS - 1)) begin
                            AUX_BUS_CLOCK <= 1'b0;
                            AUX_BUS_DATA <= 1'b0;
                            state_r <= serial_latch_pkg::ST_IDLE;
                        end else begin
                            AUX_BUS_CLOCK <= ~AUX_BUS_CLOCK;
                            if (AUX_BUS_CLOCK) begin
                                AUX_BUS_DATA <= sh_r[23];
                                sh_r <= {sh_r[22:0], 1'b0};
                            end
                        end
                    end else begin
                        half_r <= half_r + 9'h001;
                    end
                end
                default: state_r <= serial_latch_pkg::ST_IDLE;
            endcase
        end
    end

    assign fire_primary = en && bfall && cnt_r == 5'(`WORD_BITS) &&
        state_r == serial_latch_pkg::ST_P_SHIFT;
    assign fire = fire_primary || (en && state_r == serial_latch_pkg::ST_A_SHIFT &&
        half_r == 9'(AUX_HALF - 1) && phase_r == 6'(2 * `WORD_BITS - 1));
    assign recv_load = en && bfall && state_r == serial_latch_pkg::ST_P_RECV &&
        cnt_r == 5'(`ANSWER_FIRST_EDGE + `WORD_BITS - 2);
    assign rx_word = {rsh_r[22:0], sdi_s2};

    // ****************************************
    // Latches and events
    // ****************************************
    logic [3:0] pulse_r;
    logic [7:0] lat_cnt_r;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pulse_r <= 4'h0;
            lat_cnt_r <= 8'h00;
        end else if (fire) begin
            lat_cnt_r <= 8'(LATCH_CYC - 1);
            pulse_r <= fire_primary ? {2'b00, ctrl_r.latch1_sel, ctrl_r.latch0_sel} :
                {ctrl_r.latch3_sel, ctrl_r.latch2_sel, 2'b00};
        end else if (lat_cnt_r != 8'h00) begin
            lat_cnt_r <= lat_cnt_r - 8'h01;
        end else begin
            pulse_r <= 4'h0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            l3_run_r <= 1'b0;
        end else if (fire_primary && !ctrl_r.latch1_sel && !ctrl_r.latch0_sel) begin
            l3_run_r <= 1'b1;
        end else if (width_r == 7'h00) begin
            l3_run_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            LATCH <= 4'h0;
            SEND_DONE <= 1'b0;
            done_dly_r <= 1'b0;
        end else begin
            LATCH[2:0] <= pulse_r[2:0];
            LATCH[3] <= pulse_r[3] | (l3_run_r && width_r != 7'h00) |
                power_r[`POWER_HOLD_L3_BIT];
            done_dly_r <= fire;
            SEND_DONE <= done_dly_r;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx0_r <= 8'h00;
            rx1_r <= 8'h00;
            rx2_r <= 8'h00;
            RECEIVE_DONE_IRQ <= 1'b0;
        end else begin
            RECEIVE_DONE_IRQ <= recv_load;
            if (recv_load) begin
                {rx0_r, rx1_r, rx2_r} <= rx_word;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_release_after_send;
        @(posedge CLK) disable iff (!rst_n)
        fire_primary |=> !SERIAL_OE;
    endproperty
    a_release_after_send: assert property (p_release_after_send)
        else $error("data line still driven after send");

    property p_done_with_latch;
        @(posedge CLK) disable iff (!rst_n)
        SEND_DONE |-> ((LATCH & pulse_r) == pulse_r) && (LATCH[3] || !l3_run_r);
    endproperty
    a_done_with_latch: assert property (p_done_with_latch)
        else $error("send done without latch");

    property p_ctrl_cleared;
        @(posedge CLK) disable iff (!rst_n)
        (fire && !WR) |=> ctrl_r == 8'h00;
    endproperty
    a_ctrl_cleared: assert property (p_ctrl_cleared)
        else $error("control word not cleared");

    property p_aux_data_idle;
        @(posedge CLK) disable iff (!rst_n)
        state_r != serial_latch_pkg::ST_A_SHIFT |-> !AUX_BUS_DATA && !AUX_BUS_CLOCK;
    endproperty
    a_aux_data_idle: assert property (p_aux_data_idle)
        else $error("aux bus active while idle");

    property p_latch0_width;
        @(posedge CLK) disable iff (!rst_n)
        $fell(LATCH[0]) |-> $past(LATCH[0], LATCH_CYC);
    endproperty
    a_latch0_width: assert property (p_latch0_width)
        else $error("latch 0 pulse too short");

    property p_latch0_ends;
        @(posedge CLK) disable iff (!rst_n)
        $rose(LATCH[0]) |-> ##[1:40] !LATCH[0];
    endproperty
    a_latch0_ends: assert property (p_latch0_ends)
        else $error("latch 0 pulse too long");

    property p_width_zero_ends;
        @(posedge CLK) disable iff (!rst_n)
        (WR && ADDR == `REG_L3_WIDTH && WDATA[6:0] == 7'h00 && !power_r[0] && !pulse_r[3])
            |=> ##1 !LATCH[3];
    endproperty
    a_width_zero_ends: assert property (p_width_zero_ends)
        else $error("latch 3 not ended by zero width");

    property p_powerdown_freeze;
        @(posedge CLK) disable iff (!rst_n)
        !en |=> $stable(state_r);
    endproperty
    a_powerdown_freeze: assert property (p_powerdown_freeze)
        else $error("sequencer moved while powered down");

    property p_shift_on_fall;
        @(posedge CLK) disable iff (!rst_n)
        (state_r == serial_latch_pkg::ST_P_SHIFT && !bfall) |=> $stable(SERIAL_O);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall)
        else $error("data changed away from a falling edge");

endmodule

`default_nettype wire

// ### serial_latch_bus_master_tb_top.sv
`timescale 1ns/10ps
`include "serial_latch_map.svh"
`default_nettype none

module serial_latch_bus_master_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bus_clk = 1'b0;
    logic ans_en = 1'b0;
    logic [7:0] rdata;
    logic [3:0] latch;
    logic bclk_out, ser_o, ser_oe, aux_clk, aux_dat, send_done, rx_done, s_drv, s_oe;
    logic aux_prev = 1'b0;
    logic [23:0] got;
    logic [23:0] aux_word = 24'h000000;
    int fail_count = 0;
    int num_checks = 0;
    int aux_rises = 0;
    int d;
    int t;
    logic [7:0] v;

    // ****************************************
    // Clocks and instances
    // ****************************************
    always #12.5 clk = ~clk;

    // The bus clock is offset so its edges never line up with the system clock.
    initial begin
        #3;
        forever #100 bus_clk = ~bus_clk;
    end

    serial_latch_bus_master #(.LATCH_CYC(4), .AUX_HALF(4)) i_dut (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .BUS_CLOCK_IN(bus_clk), .BUS_CLOCK_OUT(bclk_out),
        .SERIAL_I(ser_oe ? ser_o : s_drv), .SERIAL_O(ser_o), .SERIAL_OE(ser_oe),
        .LATCH(latch), .AUX_BUS_CLOCK(aux_clk), .AUX_BUS_DATA(aux_dat),
        .SEND_DONE(send_done), .RECEIVE_DONE_IRQ(rx_done)
    );

    serial_slave_model i_slave (
        .bus_clk(bus_clk), .line(ser_o), .line_oe(ser_oe), .latch(latch),
        .answer_en(ans_en), .answer(24'h5ac30f), .got(got), .drv(s_drv), .drv_oe(s_oe)
    );

    // Auxiliary word is taken at the aux clock rise, midway between data changes.
    always @(posedge clk) begin
        aux_prev <= aux_clk;
        if (aux_clk && !aux_prev) begin
            aux_word <= {aux_word[22:0], aux_dat};
            aux_rises <= aux_rises + 1;
        end
        if (ser_oe && s_oe) begin
            chk(32'h1, 32'h0);
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] dat);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] dat);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        dat = rdata;
    endtask

    task automatic wait_evt(input int sel, input int limit);
        int k;
        k = 0;
        while (((sel == 0) ? send_done : rx_done) !== 1'b1) begin
            if (k == limit) begin
                fail_count++;
                print_verdict();
            end else begin
                k++;
                @(posedge clk);
            end
        end
    endtask

    task automatic idle_watch(output int done_seen, output int toggles);
        logic last;
        done_seen = 0;
        toggles = 0;
        last = bclk_out;
        repeat (300) begin
            @(posedge clk);
            done_seen += int'(send_done === 1'b1);
            toggles += int'(bclk_out !== last);
            last = bclk_out;
        end
    endtask

    task automatic xfer(input logic [7:0] ctl, input logic [3:0] lat, input logic [23:0] word,
                        input int lo, input int hi);
        int r0;
        int n;
        logic [7:0] c;
        r0 = aux_rises;
        wr_reg(`REG_TX_FIRST, word[23:16]);
        wr_reg(`REG_TX_SECOND, word[15:8]);
        wr_reg(`REG_TX_THIRD, word[7:0]);
        wr_reg(`REG_CONTROL, ctl);
        wait_evt(0, 2000);
        chk(32'(latch), 32'(lat));
        n = 0;
        while ((latch & lat) !== 4'h0 && n < 5000) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
        chk(32'(ser_oe), 32'h0);
        chk(32'({aux_clk, aux_dat}), 32'h0);
        if (ctl[6]) begin
            chk(32'(got), 32'(word));
        end else begin
            chk(32'(aux_word), 32'(word));
            chk(32'(aux_rises - r0), 32'd24);
        end
        rd_reg(`REG_CONTROL, c);
        chk(32'(c), 32'h0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({latch, ser_oe, aux_clk, aux_dat}), 32'h0);
        rd_reg(`REG_CONTROL, v);
        chk(32'(v), 32'(`CONTROL_RESET));
        rd_reg(4'hb, v);
        chk(32'(v), 32'h0);
        rd_reg(`REG_STATUS, v);
        chk(32'(v), 32'h01);
        xfer(8'hc1, 4'h1, 24'ha53c81, 4, 4);
        xfer(8'hc2, 4'h2, 24'h800001, 4, 4);
        ans_en <= 1'b1;
        xfer(8'he2, 4'h2, 24'h3c3c3c, 4, 4);
        wait_evt(1, 1000);
        ans_en <= 1'b0;
        rd_reg(`REG_RX_FIRST, v);
        chk(32'(v), 32'h5a);
        rd_reg(`REG_RX_SECOND, v);
        chk(32'(v), 32'hc3);
        rd_reg(`REG_RX_THIRD, v);
        chk(32'(v), 32'h0f);
        // Two steps of 100 bus periods at 200 ns each, give or take sync delay.
        wr_reg(`REG_L3_WIDTH, 8'h02);
        xfer(8'hc0, 4'h8, 24'h0ff0a5, 1590, 1620);
        xfer(8'h84, 4'h4, 24'hc35a96, 4, 4);
        xfer(8'h88, 4'h8, 24'h1248f0, 4, 4);
        wr_reg(`REG_L3_WIDTH, 8'h7f);
        wr_reg(`REG_CONTROL, 8'hc0);
        wait_evt(0, 2000);
        repeat (20) @(posedge clk);
        chk(32'(latch), 32'h8);
        wr_reg(`REG_L3_WIDTH, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'(latch), 32'h0);
        wr_reg(`REG_POWER, 8'h01);
        @(posedge clk);
        chk(32'(latch), 32'h8);
        wr_reg(`REG_POWER, 8'h00);
        wr_reg(`REG_CONTROL, 8'h41);
        idle_watch(d, t);
        chk(32'(d), 32'h0);
        chk(32'(latch), 32'h0);
        wr_reg(`REG_POWER, 8'h80);
        wr_reg(`REG_CONTROL, 8'hc1);
        idle_watch(d, t);
        chk(32'(d), 32'h0);
        chk(32'(t > 20), 32'h1);
        wr_reg(`REG_POWER, 8'h00);
        wait_evt(0, 2000);
        chk(32'(latch), 32'h1);
        repeat (10) @(posedge clk);
        print_verdict();
    end
endmodule

`default_nettype wire

// ### serial_latch_map.svh
`ifndef SERIAL_LATCH_MAP_SVH
`define SERIAL_LATCH_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_TX_FIRST 4'h0
`define REG_TX_SECOND 4'h1
`define REG_TX_THIRD 4'h2
`define REG_CONTROL 4'h3
`define REG_L3_WIDTH 4'h4
`define REG_POWER 4'h5
`define REG_RX_FIRST 4'h6
`define REG_RX_SECOND 4'h7
`define REG_RX_THIRD 4'h8
`define REG_STATUS 4'h9

// ****************************************
// Field positions and reset values
// ****************************************
`define POWER_DOWN_BIT 7
`define POWER_HOLD_L3_BIT 0
`define CONTROL_RESET 8'h00
`define POWER_RESET 8'h00
`define WIDTH_RESET 7'h00

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 40000000
`define LATCH_PULSE_NS 500
`define LATCH_PULSE_CYC ((`LATCH_PULSE_NS * (`CLK_HZ / 1000000)) / 1000)
`define AUX_CLK_HZ 126000
`define AUX_HALF_CYC (`CLK_HZ / (2 * `AUX_CLK_HZ))
`define WIDTH_STEP_PERIODS 100
`define WORD_BITS 24
`define ANSWER_FIRST_EDGE 5

`endif

// ### serial_latch_pkg.sv
`default_nettype none

package serial_latch_pkg;

    // Transfer control word as software writes it.
    typedef struct packed {
        logic go;
        logic bus_select_bit;
        logic answer_request;
        logic spare;
        logic latch3_sel;
        logic latch2_sel;
        logic latch1_sel;
        logic latch0_sel;
    } transfer_control_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_P_SHIFT = 4'b0010,
        ST_P_RECV = 4'b0100,
        ST_A_SHIFT = 4'b1000
    } xfer_state_t;

endpackage

`default_nettype wire

// ### serial_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Slave chip on the primary bus
// ****************************************
module serial_slave_model (
    // Bus pins as seen by the slave
    input wire logic bus_clk,
    input wire logic line,
    input wire logic line_oe,
    input wire logic [3:0] latch,
    // Answer control
    input wire logic answer_en,
    input wire logic [23:0] answer,
    // Captured word and answer drive
    output logic [23:0] got = 24'h000000,
    output logic drv = 1'b0,
    output logic drv_oe = 1'b0
);
    int rises = 99;
    logic armed = 1'b0;

    // Shift in on the bus clock fall while the master drives.
    always @(negedge bus_clk) begin
        if (line_oe) begin
            got <= {got[22:0], line};
        end
    end

    // The rise that finds latch 0 or 1 high is rise zero of the answer window.
    // Only a transfer latched while answer_en is set arms an answer.
    // Data change on rises 4 to 27, so they are stable across falls 5 to 28.
    // A released line toggles, so a stale value can never pass for data.
    always @(posedge bus_clk) begin
        if (|latch[1:0]) begin
            rises <= 0;
            armed <= answer_en;
        end else begin
            rises <= rises + 1;
        end
        if (armed && rises >= 3 && rises <= 26) begin
            drv_oe <= 1'b1;
            drv <= answer[26 - rises];
        end else begin
            drv_oe <= 1'b0;
            drv <= ~drv;
        end
    end
endmodule

`default_nettype wire
